// ---- icda_bridge.sv ----
// icda_bridge.sv: avalon slave registers of the indirect access bridge
`timescale 1ns/1ps
module icda_bridge
  import icda_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // avalon-mm slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [1:0]       avs_response,
  // inner subsystem bus
  output logic             in_req,
  output logic             in_write,
  output logic [31:0]      in_addr,
  output logic [31:0]      in_wdata,
  input  wire logic        in_gnt,
  input  wire logic        in_rvalid,
  input  wire logic        in_err,
  input  wire logic [31:0] in_rdata,
  // interrupt
  output logic             irq
);
  logic        wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  resp_r, resp_nxt;
  logic [31:0] addr_r, addr_nxt, data_r, data_nxt;
  logic        busy_r, busy_nxt, err_r, err_nxt;
  logic        busy_cap_r, busy_cap_nxt, err_cap_r, err_cap_nxt;
  logic        incr_r, incr_nxt;
  logic [1:0]  ist_r, ist_nxt, imsk_r, imsk_nxt;
  logic        irq_r, irq_nxt;
  logic        start, start_write;
  logic        done, done_err;
  logic [31:0] done_rdata;
  logic        acc, is_rd, is_wr;
  logic        hit_launch, hit_auto, hit_pass, hit_data;

  icda_inner_master u_master (
    .sys_clk     (sys_clk),
    .nrst        (nrst),
    .start       (start),
    .start_write (start_write),
    .start_addr  (addr_r),
    .start_wdata (avs_writedata),
    .done        (done),
    .done_err    (done_err),
    .done_rdata  (done_rdata),
    .in_req      (in_req),
    .in_write    (in_write),
    .in_addr     (in_addr),
    .in_wdata    (in_wdata),
    .in_gnt      (in_gnt),
    .in_rvalid   (in_rvalid),
    .in_err      (in_err),
    .in_rdata    (in_rdata)
  );

  // ==========================================================
  // bus decode: every access takes exactly one wait cycle
  always_comb
  begin
    acc        = (avs_read | avs_write) & wait_r;
    is_rd      = acc & avs_read;
    is_wr      = acc & avs_write & ~avs_read;
    hit_launch = (avs_address == ICDA_OFS_LAUNCH);
    hit_auto   = (avs_address == ICDA_OFS_AUTOINC);
    hit_pass   = (avs_address == ICDA_OFS_PASSIVE);
    hit_data   = hit_launch | hit_auto | hit_pass;
    // launching views start an access; passive never does
    start       = acc & (hit_launch | hit_auto) & ~busy_r;
    start_write = is_wr;
  end

  // ==========================================================
  // registers
  always_comb
  begin
    wait_nxt     = 1'b1;
    rdata_nxt    = rdata_r;
    resp_nxt     = resp_r;
    addr_nxt     = addr_r;
    data_nxt     = data_r;
    busy_nxt     = busy_r;
    err_nxt      = err_r;
    busy_cap_nxt = busy_cap_r;
    err_cap_nxt  = err_cap_r;
    incr_nxt     = incr_r;
    ist_nxt      = ist_r;
    imsk_nxt     = imsk_r;
    if (acc)
    begin
      wait_nxt  = 1'b0;
      resp_nxt  = 2'b00;
      rdata_nxt = ICDA_RST_WORD;
    end
    // read data: previous result, or marker while busy
    if (is_rd)
    begin
      case (avs_address)
        ICDA_OFS_CTRL:
          rdata_nxt = {28'h000_0000, err_cap_r, err_r, busy_cap_r, busy_r};
        ICDA_OFS_ADDR:    rdata_nxt = addr_r;
        ICDA_OFS_LAUNCH,
        ICDA_OFS_AUTOINC,
        ICDA_OFS_PASSIVE: rdata_nxt = busy_r ? ICDA_BUSY_WORD : data_r;
        ICDA_OFS_IRQ_ST:  rdata_nxt = {30'h0000_0000, ist_r};
        ICDA_OFS_IRQ_MSK: rdata_nxt = {30'h0000_0000, imsk_r};
        default:          resp_nxt  = 2'b10;
      endcase
      if (hit_data)
      begin
        busy_cap_nxt = busy_r;
        err_cap_nxt  = err_r;
      end
    end
    if (is_wr)
    begin
      case (avs_address)
        ICDA_OFS_CTRL:    ;
        ICDA_OFS_ADDR:    addr_nxt = avs_writedata;
        ICDA_OFS_LAUNCH,
        ICDA_OFS_AUTOINC:
        begin
          if (!busy_r)
            data_nxt = avs_writedata;
        end
        ICDA_OFS_PASSIVE: data_nxt = avs_writedata;
        ICDA_OFS_IRQ_ST:  ;
        ICDA_OFS_IRQ_MSK: imsk_nxt = avs_writedata[1:0];
        default:          resp_nxt = 2'b10;
      endcase
    end
    // read of status clears it; a new event below wins
    if (is_rd && avs_address == ICDA_OFS_IRQ_ST)
      ist_nxt = 2'b00;
    if (start)
    begin
      busy_nxt = 1'b1;
      err_nxt  = 1'b0;
      incr_nxt = hit_auto;
    end
    if (done)
    begin
      busy_nxt = 1'b0;
      err_nxt  = done_err;
      if (!in_write)
        data_nxt = done_rdata;
      if (incr_r)
        addr_nxt = addr_r + ICDA_ADDR_STEP;
      ist_nxt[ICDA_IRQ_DONE] = 1'b1;
      if (done_err)
        ist_nxt[ICDA_IRQ_FAULT] = 1'b1;
    end
    irq_nxt = |(ist_nxt & imsk_nxt);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      wait_r     <= 1'b1;
      rdata_r    <= ICDA_RST_WORD;
      resp_r     <= 2'b00;
      addr_r     <= ICDA_RST_WORD;
      data_r     <= ICDA_RST_WORD;
      busy_r     <= 1'b0;
      err_r      <= 1'b0;
      busy_cap_r <= 1'b0;
      err_cap_r  <= 1'b0;
      incr_r     <= 1'b0;
      ist_r      <= ICDA_RST_IRQ;
      imsk_r     <= ICDA_RST_IRQ;
      irq_r      <= 1'b0;
    end
    else
    begin
      wait_r     <= wait_nxt;
      rdata_r    <= rdata_nxt;
      resp_r     <= resp_nxt;
      addr_r     <= addr_nxt;
      data_r     <= data_nxt;
      busy_r     <= busy_nxt;
      err_r      <= err_nxt;
      busy_cap_r <= busy_cap_nxt;
      err_cap_r  <= err_cap_nxt;
      incr_r     <= incr_nxt;
      ist_r      <= ist_nxt;
      imsk_r     <= imsk_nxt;
      irq_r      <= irq_nxt;
    end
  end

  assign avs_waitrequest = wait_r;
  assign avs_readdata    = rdata_r;
  assign avs_response    = resp_r;
  assign irq             = irq_r;
endmodule

// ---- icda_pkg.sv ----
// icda_pkg.sv: constants, register map and state types of the indirect access bridge
// What this block does
// - An access launched through the auto-increment data view adds 4 to the address when busy clears.
// - A read or write of the launching data view while busy is clear starts an access at the held address.
// - A data view read while busy is allowed and returns 0x80000000.
// - A write to the launching or auto-increment view while not busy issues one full-word write carrying that value to the held address.
// - A data view read returns the previous access result; the new result is ready when busy clears.
// - Reading a result from a launching view starts another read, so streaming works.
// - The passive data view never starts an access, also takes writes while busy, and otherwise behaves like the launching view.
// - A write to the passive view replaces the shared data value without any transaction.
// - Busy is set by hardware when an access begins and cleared when it ends.
// - An errored access sets the fault flag, and an errored read yields 0x80000000.
// - Every data view read copies busy and fault into captured flags.
package icda_pkg;
  // ==========================================================
  // register map (byte addresses of word registers)
  localparam logic [5:0]  ICDA_OFS_CTRL    = 6'h00;
  localparam logic [5:0]  ICDA_OFS_ADDR    = 6'h04;
  localparam logic [5:0]  ICDA_OFS_LAUNCH  = 6'h08;
  localparam logic [5:0]  ICDA_OFS_AUTOINC = 6'h0C;
  localparam logic [5:0]  ICDA_OFS_PASSIVE = 6'h10;
  localparam logic [5:0]  ICDA_OFS_IRQ_ST  = 6'h14;
  localparam logic [5:0]  ICDA_OFS_IRQ_MSK = 6'h18;
  // ==========================================================
  // control register fields
  localparam int          ICDA_BIT_BUSY    = 0;
  localparam int          ICDA_BIT_BUSY_RD = 1;
  localparam int          ICDA_BIT_ERR     = 2;
  localparam int          ICDA_BIT_ERR_RD  = 3;
  // interrupt fields: access done, access fault
  localparam int          ICDA_IRQ_DONE    = 0;
  localparam int          ICDA_IRQ_FAULT   = 1;
  // ==========================================================
  // values
  localparam logic [31:0] ICDA_RST_WORD    = 32'h0000_0000;
  localparam logic [31:0] ICDA_BUSY_WORD   = 32'h8000_0000;
  localparam logic [31:0] ICDA_ADDR_STEP   = 32'h0000_0004;
  localparam logic [31:0] ICDA_UNMAPPED    = 32'hDEAD_BEEF;
  localparam logic [1:0]  ICDA_RST_IRQ     = 2'h0;
  typedef enum logic [1:0] {
    ICDA_IDLE = 2'b00,
    ICDA_REQ  = 2'b01,
    ICDA_WAIT = 2'b11
  } icda_state_t;
endpackage

// ---- icda_inner_master.sv ----
// icda_inner_master.sv: single-word master on the inner subsystem bus
`timescale 1ns/1ps
module icda_inner_master
  import icda_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // launch side
  input  wire logic        start,
  input  wire logic        start_write,
  input  wire logic [31:0] start_addr,
  input  wire logic [31:0] start_wdata,
  output logic             done,
  output logic             done_err,
  output logic [31:0]      done_rdata,
  // inner bus
  output logic             in_req,
  output logic             in_write,
  output logic [31:0]      in_addr,
  output logic [31:0]      in_wdata,
  input  wire logic        in_gnt,
  input  wire logic        in_rvalid,
  input  wire logic        in_err,
  input  wire logic [31:0] in_rdata
);
  icda_state_t state_r, state_nxt;
  logic        req_r, req_nxt, wr_r, wr_nxt, done_r, done_nxt, err_r, err_nxt;
  logic [31:0] addr_r, addr_nxt, wd_r, wd_nxt, rd_r, rd_nxt;

  // ==========================================================
  // request and response
  always_comb
  begin
    state_nxt = state_r;
    req_nxt   = req_r;
    wr_nxt    = wr_r;
    addr_nxt  = addr_r;
    wd_nxt    = wd_r;
    rd_nxt    = rd_r;
    err_nxt   = err_r;
    done_nxt  = 1'b0;
    case (state_r)
      ICDA_IDLE:
        if (start)
        begin
          state_nxt = ICDA_REQ;
          req_nxt   = 1'b1;
          wr_nxt    = start_write;
          addr_nxt  = {start_addr[31:2], 2'b00};
          wd_nxt    = start_wdata;
        end
      ICDA_REQ:
        if (in_gnt)
        begin
          req_nxt   = 1'b0;
          state_nxt = ICDA_WAIT;
        end
      ICDA_WAIT:
        if (in_rvalid)
        begin
          state_nxt = ICDA_IDLE;
          done_nxt  = 1'b1;
          err_nxt   = in_err;
          // faulted reads carry the fixed marker word
          rd_nxt    = in_err ? ICDA_BUSY_WORD : in_rdata;
        end
      default:
      begin
        state_nxt = ICDA_IDLE;
        req_nxt   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      state_r <= ICDA_IDLE;
      req_r   <= 1'b0;
      wr_r    <= 1'b0;
      addr_r  <= ICDA_RST_WORD;
      wd_r    <= ICDA_RST_WORD;
      rd_r    <= ICDA_RST_WORD;
      err_r   <= 1'b0;
      done_r  <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      req_r   <= req_nxt;
      wr_r    <= wr_nxt;
      addr_r  <= addr_nxt;
      wd_r    <= wd_nxt;
      rd_r    <= rd_nxt;
      err_r   <= err_nxt;
      done_r  <= done_nxt;
    end
  end

  assign in_req     = req_r;
  assign in_write   = wr_r;
  assign in_addr    = addr_r;
  assign in_wdata   = wd_r;
  assign done       = done_r;
  assign done_err   = err_r;
  assign done_rdata = rd_r;
endmodule

// ---- icda_props.sv ----
// icda_props.sv: port checker of the bridge
`timescale 1ns/1ps
module icda_props
  import icda_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        nrst,
  // register bus
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // inner bus
  input wire logic        in_req,
  input wire logic        in_write,
  input wire logic [31:0] in_addr,
  input wire logic [31:0] in_wdata,
  input wire logic        in_gnt,
  input wire logic        in_rvalid
);
  // ==========================================
  // granted access still waiting for its answer
  logic out_r;
  logic out_nxt;
  logic late_r;
  logic quiet;
  always_comb
    out_nxt = !in_rvalid && (out_r || (in_req && in_gnt));
  always_ff @(posedge sys_clk)
    out_r <= nrst && out_nxt;
  // busy outlives the answer by one more cycle inside the bridge
  always_ff @(posedge sys_clk)
    late_r <= nrst && in_rvalid;
  assign quiet = !in_req && !out_r && !late_r;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_ack;
    (avs_read || avs_write) && !avs_waitrequest;
  endsequence
  sequence s_hit(logic [5:0] a);
    s_ack ##0 (avs_address == a);
  endsequence
  // first wait cycle of a request made while the inner side is idle;
  // the launch is decided here, so idleness is judged here too
  sequence s_req(logic [5:0] a);
    (avs_read || avs_write) && avs_waitrequest && (avs_address == a) && quiet;
  endsequence
  property p_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("no answer after one wait state");
  property p_stand;
    s_ack |=> avs_waitrequest;
  endproperty
  a_stand: assert property (p_stand) else $error("answer held too long");
  property p_wr;
    s_req(ICDA_OFS_LAUNCH) ##0 avs_write ##1 s_hit(ICDA_OFS_LAUNCH)
      |=> in_req && in_write && in_wdata == $past(avs_writedata);
  endproperty
  a_wr: assert property (p_wr) else $error("launch write not issued");
  property p_rd;
    s_req(ICDA_OFS_LAUNCH) ##0 avs_read ##1 s_hit(ICDA_OFS_LAUNCH)
      |=> in_req && !in_write;
  endproperty
  a_rd: assert property (p_rd) else $error("launch read not issued");
  property p_inert;
    s_req(ICDA_OFS_PASSIVE) ##1 s_hit(ICDA_OFS_PASSIVE) |-> !in_req [*2];
  endproperty
  a_inert: assert property (p_inert) else $error("passive view started access");
  property p_busy;
    s_hit(ICDA_OFS_LAUNCH) ##0 avs_read && out_r |-> avs_readdata == ICDA_BUSY_WORD;
  endproperty
  a_busy: assert property (p_busy) else $error("busy read value wrong");
  property p_hold;
    in_req && !in_gnt |=> in_req && $stable(in_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped early");
  property p_drop;
    in_req && in_gnt |=> !in_req;
  endproperty
  a_drop: assert property (p_drop) else $error("request kept after grant");
endmodule
bind icda_bridge icda_props u_props (.*);

// ---- icda_mem.sv ----
// icda_mem.sv: inner bus target with a slow mode and a faulting region
`timescale 1ns/1ps
module icda_mem
(
  // clock, reset, pace
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic        slow,
  // inner bus
  input wire logic        in_req,
  input wire logic        in_write,
  input wire logic [31:0] in_addr,
  input wire logic [31:0] in_wdata,
  output logic            in_gnt,
  output logic            in_rvalid,
  output logic            in_err,
  output logic [31:0]     in_rdata
);
  logic [31:0] mem [16];
  logic [31:0] adr;
  logic        pend;
  logic        wr;
  logic [3:0]  cnt;
  always @(posedge sys_clk)
  begin
    in_gnt <= 1'b0;
    in_rvalid <= 1'b0;
    in_err <= 1'b0;
    // no stale data between answers
    in_rdata <= ~in_rdata;
    if (!nrst)
    begin
      pend <= 1'b0;
      in_rdata <= 32'h0000_0000;
      mem <= '{default: 32'h0000_0000};
    end
    else if (in_req && in_gnt)
    begin
      pend <= 1'b1;
      wr <= in_write;
      adr <= in_addr;
      cnt <= slow ? 4'h8 : 4'h0;
      if (in_write && !in_addr[12])
        mem[in_addr[5:2]] <= in_wdata;
    end
    else if (in_req && !pend)
      in_gnt <= 1'b1;
    else if (pend && cnt != 4'h0)
      cnt <= cnt - 4'h1;
    else if (pend)
    begin
      pend <= 1'b0;
      in_rvalid <= 1'b1;
      // region at bit 12 faults
      in_err <= adr[12];
      if (!wr && !adr[12])
        in_rdata <= mem[adr[5:2]];
    end
  end
endmodule

// ---- indirect_cpu_domain_access_test.sv ----
// indirect_cpu_domain_access_test.sv: register level bench of the bridge
`timescale 1ns/1ps
module indirect_cpu_domain_access_test
  import icda_pkg::*;
;
  logic        sys_clk, nrst, avs_read, avs_write, avs_waitrequest, slow, irq;
  logic        in_req, in_write, in_gnt, in_rvalid, in_err;
  logic [5:0]  avs_address;
  logic [3:0]  avs_byteenable;
  logic [1:0]  avs_response, rs;
  logic [31:0] avs_writedata, avs_readdata, in_addr, in_wdata, in_rdata, q;
  logic [5:0]  rst_ofs [4] = '{ICDA_OFS_CTRL, ICDA_OFS_ADDR, ICDA_OFS_PASSIVE, ICDA_OFS_IRQ_ST};
  int          n_fail, num_checks;
  icda_bridge uut (.*);
  icda_mem far_end (.*);
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // ==========================================
  // bus tasks
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    // no cycle budget here: only the watchdog ends a wait
    do
    begin
      @(posedge sys_clk);
    end
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    rs = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, e, q);
  endtask
  // poll busy; no launch while it is set
  task automatic idle();
    do
    begin
      bus(1'b0, ICDA_OFS_CTRL, 32'h0000_0000);
    end
    while (q[ICDA_BIT_BUSY] !== 1'b0);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    stop_test();
  end
  // ==========================================
  // tests
  initial
  begin
    {nrst, avs_read, avs_write, slow, avs_address, avs_writedata, q} = '0;
    avs_byteenable = 4'hF;
    n_fail = 0;
    num_checks = 0;
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    foreach (rst_ofs[i])
      rd(rst_ofs[i], 32'h0000_0000, "reset");
    bus(1'b1, ICDA_OFS_ADDR, 32'h0000_0010);
    bus(1'b1, ICDA_OFS_LAUNCH, 32'hA5A5_0001);
    idle();
    rd(ICDA_OFS_CTRL, 32'h0000_0000, "ctrl");
    bus(1'b1, ICDA_OFS_PASSIVE, 32'h1234_5678);
    rd(ICDA_OFS_PASSIVE, 32'h1234_5678, "passive");
    $display("write test done");
    slow <= 1'b1;
    rd(ICDA_OFS_LAUNCH, 32'h1234_5678, "old");
    rd(ICDA_OFS_LAUNCH, ICDA_BUSY_WORD, "busy");
    rd(ICDA_OFS_CTRL, 32'h0000_0003, "flags");
    idle();
    rd(ICDA_OFS_LAUNCH, 32'hA5A5_0001, "stream");
    idle();
    rd(ICDA_OFS_PASSIVE, 32'hA5A5_0001, "latch");
    $display("read test done");
    slow <= 1'b0;
    bus(1'b1, ICDA_OFS_ADDR, 32'h0000_0020);
    bus(1'b1, ICDA_OFS_AUTOINC, 32'h0000_BEEF);
    idle();
    rd(ICDA_OFS_ADDR, 32'h0000_0024, "inc");
    rd(ICDA_OFS_AUTOINC, 32'h0000_BEEF, "incdata");
    idle();
    rd(ICDA_OFS_ADDR, 32'h0000_0028, "inc2");
    rd(ICDA_OFS_PASSIVE, 32'h0000_0000, "mem");
    $display("increment test done");
    bus(1'b1, ICDA_OFS_IRQ_MSK, 32'h0000_0000);
    rd(ICDA_OFS_IRQ_ST, 32'h0000_0001, "done");
    bus(1'b1, ICDA_OFS_ADDR, 32'h0000_1000);
    bus(1'b0, ICDA_OFS_LAUNCH, 32'h0000_0000);
    idle();
    chk("masked", 32'h0000_0000, {31'h0000_0000, irq});
    rd(ICDA_OFS_PASSIVE, ICDA_BUSY_WORD, "errdata");
    rd(ICDA_OFS_CTRL, 32'h0000_000C, "errflags");
    bus(1'b1, ICDA_OFS_IRQ_MSK, 32'h0000_0002);
    repeat (2) @(posedge sys_clk);
    chk("irq", 32'h0000_0001, {31'h0000_0000, irq});
    rd(ICDA_OFS_IRQ_ST, 32'h0000_0003, "status");
    repeat (2) @(posedge sys_clk);
    chk("irqclr", 32'h0000_0000, {31'h0000_0000, irq});
    rd(6'h3C, 32'h0000_0000, "unmapped");
    chk("resp", 32'h0000_0002, {30'h0000_0000, rs});
    $display("fault test done");
    stop_test();
  end
endmodule
